// >>> mtl_pkg.sv
// constants for the memory type range lookup block
package mtl_pkg;
    // register index space of the model-specific register port
    localparam logic [4:0] IDX_FIX_E0000 = 5'h00;
    localparam logic [4:0] IDX_FIX_E8000 = 5'h01;
    localparam logic [4:0] IDX_FIX_F0000 = 5'h02;
    localparam logic [4:0] IDX_FIX_F8000 = 5'h03;
    localparam logic [4:0] IDX_DEF_CTRL  = 5'h04;
    // var_range_base n at 10h+2n, var_range_mask n at 11h+2n
    localparam logic [4:0] IDX_VAR_FIRST = 5'h10;
    localparam int         IDX_VAR_BIT   = 4;

    // default_type_ctrl fields
    localparam int DEF_TYPE_LSB  = 0;
    localparam int DEF_FE_BIT    = 10;
    localparam int DEF_E_BIT     = 11;
    // var_range_base / var_range_mask fields
    localparam int VAR_ADDR_LSB  = 12;
    localparam int MASK_VLD_BIT  = 11;
    localparam int TYPE_W        = 8;

    // fixed 4-Kbyte ranges cover E0000h..FFFFFh: address bits 19:17 all ones
    localparam logic [2:0] FIX_REGION = 3'h7;
    localparam int         FIX_TOP    = 20;

    // standard type encodings
    localparam logic [7:0] MT_UNCACHEABLE     = 8'h00;
    localparam logic [7:0] MT_WRITE_COMBINING = 8'h01;
    localparam logic [7:0] MT_WRITE_THROUGH   = 8'h04;
    localparam logic [7:0] MT_WRITE_PROTECT   = 8'h05;
    localparam logic [7:0] MT_WRITE_BACK      = 8'h06;

    // values after reset: typing off, all ranges cleared
    localparam logic [63:0] RST_REG64 = 64'h0;
    localparam logic [7:0]  RST_TYPE  = 8'h00;
    localparam logic        RST_BIT   = 1'b0;

    localparam int ARCH_PA_W = 52;
    localparam int MAX_NVAR  = 8;
endpackage

// >>> mtl_type_lookup.sv
// memory type lookup from fixed, variable and default range type registers
`timescale 1ns/100ps
module mtl_type_lookup #(
    parameter int PA_W = mtl_pkg::ARCH_PA_W,
    parameter int NVAR = mtl_pkg::MAX_NVAR
) (
    input  wire logic            CLK_I,
    input  wire logic            RSTN_I,
    input  wire logic            MSR_WR_I,
    input  wire logic            MSR_RD_I,
    input  wire logic [4:0]      MSR_IDX_I,
    input  wire logic [63:0]     MSR_WDATA_I,
    output logic      [63:0]     MSR_RDATA_O,
    output logic                 MSR_ACK_O,
    output logic                 MSR_ERR_O,
    input  wire logic [PA_W-1:0] PADDR_I,
    output logic      [7:0]      MEM_TYPE_O
);
    localparam int AW = PA_W - mtl_pkg::VAR_ADDR_LSB;

    if (PA_W < 21 || PA_W > mtl_pkg::ARCH_PA_W || NVAR < 1 || NVAR > mtl_pkg::MAX_NVAR) begin : g_chk
        $error("mtl_type_lookup: unsupported PA_W or NVAR");
    end

    typedef struct packed {
        logic [3:0][63:0]      fix;
        logic [NVAR-1:0][7:0]  btype;
        logic [NVAR-1:0][AW-1:0] base;
        logic [NVAR-1:0][AW-1:0] mask;
        logic [NVAR-1:0]       valid;
        logic                  e;
        logic                  fe;
        logic [7:0]            dtype;
        logic [63:0]           rdata;
        logic                  ack;
        logic                  err;
    } mtl_state_s;

    mtl_state_s st;
    mtl_state_s next_st;

    // true for the five standard encodings
    function automatic logic mtl_std_type(input logic [7:0] t);
        return t == mtl_pkg::MT_UNCACHEABLE || t == mtl_pkg::MT_WRITE_COMBINING
            || t == mtl_pkg::MT_WRITE_THROUGH || t == mtl_pkg::MT_WRITE_PROTECT
            || t == mtl_pkg::MT_WRITE_BACK;
    endfunction

    // true when every byte of a fixed register is a standard encoding
    function automatic logic mtl_std_fix(input logic [63:0] v);
        logic ok;
        ok = 1'b1;
        for (int k = 0; k < 8; k++) begin
            ok = ok & mtl_std_type(v[k*8 +: 8]);
        end
        return ok;
    endfunction

    // register decode
    logic            is_var;
    logic [2:0]      var_n;
    logic            is_mask;
    logic            idx_ok;
    logic            wr_ok;
    logic [63:0]     rd_val;
    logic [63:0]     hi_bits;

    always_comb begin
        is_var  = MSR_IDX_I[mtl_pkg::IDX_VAR_BIT];
        var_n   = MSR_IDX_I[3:1];
        is_mask = MSR_IDX_I[0];
        hi_bits = MSR_WDATA_I >> PA_W;
        idx_ok  = 1'b0;
        wr_ok   = 1'b0;
        rd_val  = 64'h0;
        if (is_var) begin
            idx_ok = int'(var_n) < NVAR;
            if (idx_ok) begin
                if (is_mask) begin
                    rd_val[PA_W-1:mtl_pkg::VAR_ADDR_LSB] = st.mask[var_n];
                    rd_val[mtl_pkg::MASK_VLD_BIT]        = st.valid[var_n];
                    wr_ok = hi_bits == 64'h0 && MSR_WDATA_I[10:0] == 11'h0;
                end else begin
                    rd_val[PA_W-1:mtl_pkg::VAR_ADDR_LSB] = st.base[var_n];
                    rd_val[7:0]                          = st.btype[var_n];
                    wr_ok = hi_bits == 64'h0 && MSR_WDATA_I[11:8] == 4'h0
                         && mtl_std_type(MSR_WDATA_I[7:0]);
                end
            end
        end else if (MSR_IDX_I == mtl_pkg::IDX_DEF_CTRL) begin
            idx_ok = 1'b1;
            rd_val[mtl_pkg::DEF_E_BIT]  = st.e;
            rd_val[mtl_pkg::DEF_FE_BIT] = st.fe;
            rd_val[7:0]                 = st.dtype;
            wr_ok = MSR_WDATA_I[63:12] == 52'h0 && MSR_WDATA_I[9:8] == 2'h0
                 && mtl_std_type(MSR_WDATA_I[7:0]);
        end else if (MSR_IDX_I <= mtl_pkg::IDX_FIX_F8000) begin
            idx_ok = 1'b1;
            rd_val = st.fix[MSR_IDX_I[1:0]];
            wr_ok  = mtl_std_fix(MSR_WDATA_I);
        end
    end

    // register state: writes land at the edge, lookups see them afterwards
    always_comb begin
        next_st     = st;
        next_st.ack = MSR_WR_I | MSR_RD_I;
        next_st.err = 1'b0;
        if (MSR_RD_I) begin
            next_st.rdata = rd_val;
            next_st.err   = ~idx_ok;
        end else if (MSR_WR_I) begin
            next_st.err = ~(idx_ok & wr_ok);
            if (idx_ok && wr_ok) begin
                if (is_var && is_mask) begin
                    next_st.mask[var_n]  = MSR_WDATA_I[PA_W-1:mtl_pkg::VAR_ADDR_LSB];
                    next_st.valid[var_n] = MSR_WDATA_I[mtl_pkg::MASK_VLD_BIT];
                end else if (is_var) begin
                    next_st.base[var_n]  = MSR_WDATA_I[PA_W-1:mtl_pkg::VAR_ADDR_LSB];
                    next_st.btype[var_n] = MSR_WDATA_I[7:0];
                end else if (MSR_IDX_I == mtl_pkg::IDX_DEF_CTRL) begin
                    next_st.e     = MSR_WDATA_I[mtl_pkg::DEF_E_BIT];
                    next_st.fe    = MSR_WDATA_I[mtl_pkg::DEF_FE_BIT];
                    next_st.dtype = MSR_WDATA_I[7:0];
                end else begin
                    next_st.fix[MSR_IDX_I[1:0]] = MSR_WDATA_I;
                end
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            st.fix   <= {4{mtl_pkg::RST_REG64}};
            st.btype <= {NVAR{mtl_pkg::RST_TYPE}};
            st.base  <= '0;
            st.mask  <= '0;
            st.valid <= '0;
            st.e     <= mtl_pkg::RST_BIT;
            st.fe    <= mtl_pkg::RST_BIT;
            st.dtype <= mtl_pkg::RST_TYPE;
            st.rdata <= mtl_pkg::RST_REG64;
            st.ack   <= mtl_pkg::RST_BIT;
            st.err   <= mtl_pkg::RST_BIT;
        end else begin
            st <= next_st;
        end
    end

    assign MSR_RDATA_O = st.rdata;
    assign MSR_ACK_O   = st.ack;
    assign MSR_ERR_O   = st.err;

    // address lookup, combinational so the type is ready in the same cycle
    logic [NVAR-1:0] hit;
    logic            fix_sel;
    logic [7:0]      fix_type;
    logic            any_hit;
    logic            mixed;
    logic            any_uc;
    logic            other;
    logic [7:0]      var_type;
    logic [7:0]      look;

    always_comb begin
        for (int i = 0; i < NVAR; i++) begin
            hit[i] = st.valid[i]
                  && (st.mask[i] & st.base[i]) == (st.mask[i] & PADDR_I[PA_W-1:mtl_pkg::VAR_ADDR_LSB]);
        end
        fix_sel = st.e && st.fe
               && PADDR_I[PA_W-1:mtl_pkg::FIX_TOP] == '0
               && PADDR_I[19:17] == mtl_pkg::FIX_REGION;
        fix_type = st.fix[PADDR_I[16:15]][PADDR_I[14:12]*8 +: 8];
        any_hit  = 1'b0;
        mixed    = 1'b0;
        any_uc   = 1'b0;
        other    = 1'b0;
        var_type = mtl_pkg::MT_UNCACHEABLE;
        for (int i = 0; i < NVAR; i++) begin
            if (hit[i]) begin
                if (any_hit && st.btype[i] != var_type) begin
                    mixed = 1'b1;
                end
                if (!any_hit) begin
                    var_type = st.btype[i];
                end
                any_hit = 1'b1;
                any_uc  = any_uc | (st.btype[i] == mtl_pkg::MT_UNCACHEABLE);
                other   = other | (st.btype[i] != mtl_pkg::MT_WRITE_THROUGH
                                && st.btype[i] != mtl_pkg::MT_WRITE_BACK);
            end
        end
        if (mixed && !any_uc && !other) begin
            look = mtl_pkg::MT_WRITE_THROUGH;
        end else if (mixed) begin
            // undefined mixes fall back to the safest type
            look = mtl_pkg::MT_UNCACHEABLE;
        end else begin
            look = var_type;
        end
        if (!st.e) begin
            // only the type result is forced; no I/O attribute bits pass here
            look = mtl_pkg::MT_UNCACHEABLE;
        end else if (fix_sel) begin
            look = fix_type;
        end else if (!any_hit) begin
            look = st.dtype;
        end
    end

    assign MEM_TYPE_O = look;

    // checks
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RSTN_I);

    a_req_acked:
    assert property ((MSR_WR_I || MSR_RD_I) |=> MSR_ACK_O)
        else $error("register access not acknowledged");

    a_off_uncacheable:
    assert property (!st.e |-> MEM_TYPE_O == mtl_pkg::MT_UNCACHEABLE)
        else $error("typing disabled but type not uncacheable");

    a_def_type_refuse:
    assert property (MSR_WR_I && !MSR_RD_I && MSR_IDX_I == mtl_pkg::IDX_DEF_CTRL
                     && !mtl_std_type(MSR_WDATA_I[7:0])
                     |=> MSR_ERR_O && $stable(st.dtype))
        else $error("non-standard default type accepted");

    a_base_type_refuse:
    assert property (MSR_WR_I && !MSR_RD_I && MSR_IDX_I >= mtl_pkg::IDX_VAR_FIRST && !MSR_IDX_I[0]
                     && !mtl_std_type(MSR_WDATA_I[7:0])
                     |=> MSR_ERR_O && $stable(st.btype))
        else $error("non-standard base type accepted");

    a_fixed_wins:
    assert property (st.e && st.fe && PADDR_I[PA_W-1:17] == (PA_W - 17)'(mtl_pkg::FIX_REGION)
                     |-> MEM_TYPE_O == st.fix[PADDR_I[16:15]][PADDR_I[14:12]*8 +: 8])
        else $error("fixed range type not applied");

    a_fixed_off:
    assert property (st.e && !st.fe && hit == '0 |-> MEM_TYPE_O == st.dtype)
        else $error("default type not used with fixed ranges off");

    a_valid_gate:
    assert property ((hit & ~st.valid) == '0)
        else $error("invalid pair produced a hit");

    a_uc_wins:
    assert property (st.e && !fix_sel && any_uc |-> MEM_TYPE_O == mtl_pkg::MT_UNCACHEABLE)
        else $error("uncacheable overlap did not win");

    a_def_write_lands:
    assert property (MSR_WR_I && !MSR_RD_I && MSR_IDX_I == mtl_pkg::IDX_DEF_CTRL
                     && mtl_std_type(MSR_WDATA_I[7:0]) && MSR_WDATA_I[63:12] == 52'h0
                     && MSR_WDATA_I[9:8] == 2'h0
                     |=> st.e == $past(MSR_WDATA_I[11]) && st.dtype == $past(MSR_WDATA_I[7:0]))
        else $error("default type write not taken");

    a_read_reserved:
    assert property (MSR_RD_I && MSR_IDX_I == mtl_pkg::IDX_DEF_CTRL
                     |=> MSR_RDATA_O[63:12] == 52'h0 && MSR_RDATA_O[9:8] == 2'h0)
        else $error("reserved bits read nonzero");

    a_mask_valid_write:
    assert property (MSR_WR_I && !MSR_RD_I && is_var && is_mask && idx_ok && wr_ok
                     |=> st.valid[$past(var_n)] == $past(MSR_WDATA_I[mtl_pkg::MASK_VLD_BIT]))
        else $error("mask valid flag not stored");

    a_bad_idx_err:
    assert property (MSR_RD_I && MSR_IDX_I > mtl_pkg::IDX_DEF_CTRL && MSR_IDX_I < mtl_pkg::IDX_VAR_FIRST
                     |=> MSR_ERR_O && MSR_RDATA_O == 64'h0)
        else $error("unmapped index not refused");

    a_good_read_ok:
    assert property (MSR_RD_I && MSR_IDX_I >= mtl_pkg::IDX_VAR_FIRST && int'(MSR_IDX_I[3:1]) < NVAR
                     |=> !MSR_ERR_O)
        else $error("implemented range register refused");

    a_base_read_zero:
    assert property (MSR_RD_I && MSR_IDX_I >= mtl_pkg::IDX_VAR_FIRST && !MSR_IDX_I[0]
                     |=> MSR_RDATA_O[11:8] == 4'h0 && (MSR_RDATA_O >> PA_W) == 64'h0)
        else $error("base register reserved bits read nonzero");

    a_mask_read_zero:
    assert property (MSR_RD_I && MSR_IDX_I >= mtl_pkg::IDX_VAR_FIRST && MSR_IDX_I[0]
                     |=> MSR_RDATA_O[10:0] == 11'h0 && (MSR_RDATA_O >> PA_W) == 64'h0)
        else $error("mask register reserved bits read nonzero");

    a_default_used:
    assert property (st.e && !fix_sel && hit == '0 |-> MEM_TYPE_O == st.dtype)
        else $error("uncovered address did not get default type");

    a_ack_idle:
    assert property (!MSR_WR_I && !MSR_RD_I |=> !MSR_ACK_O && !MSR_ERR_O)
        else $error("acknowledge without request");

    a_rdata_holds:
    assert property (!MSR_RD_I |=> $stable(MSR_RDATA_O))
        else $error("read data changed without a read");

    a_fix_byte_refuse:
    assert property (MSR_WR_I && !MSR_RD_I && MSR_IDX_I <= mtl_pkg::IDX_FIX_F8000
                     && !mtl_std_fix(MSR_WDATA_I)
                     |=> MSR_ERR_O && $stable(st.fix))
        else $error("non-standard fixed type accepted");

    a_fixed_needs_e:
    assert property (!st.e && st.fe && PADDR_I[19:17] == mtl_pkg::FIX_REGION
                     |-> MEM_TYPE_O == mtl_pkg::MT_UNCACHEABLE)
        else $error("fixed range active with typing disabled");

    a_enable_read_back:
    assert property (MSR_RD_I && MSR_IDX_I == mtl_pkg::IDX_DEF_CTRL
                     |=> MSR_RDATA_O[mtl_pkg::DEF_E_BIT] == $past(st.e))
        else $error("global enable read back wrong");
endmodule

// >>> mtl_core_model.sv
// core-side model: forms range register images and presents lookup addresses
`timescale 1ns/100ps
module mtl_core_model (
    input  wire logic [51:0] want_i,
    input  wire logic [51:0] base_i,
    input  wire logic [51:0] size_i,
    input  wire logic [7:0]  type_i,
    input  wire logic        vld_i,
    output logic      [51:0] paddr_o,
    output logic      [63:0] base_reg_o,
    output logic      [63:0] mask_reg_o
);
    logic [51:0] span;

    assign paddr_o = want_i;
    // callers pass power-of-two sizes of 4K or more on matching boundaries
    assign span = 52'hf_ffff_ffff_ffff - (base_i + size_i - 52'h1 - base_i);
    assign base_reg_o = {12'h0, base_i[51:12], 4'h0, type_i};
    assign mask_reg_o = {12'h0, span[51:12], vld_i, 11'h0};
endmodule

// >>> memory_type_range_lookup_tb.sv
// self-checking bench for the memory type lookup
`timescale 1ns/100ps
module memory_type_range_lookup_tb;
    logic        clk, rstn, wr, rd, ack, err, vld;
    logic [4:0]  idx;
    logic [63:0] wdata, rdata, base_reg, mask_reg;
    logic [51:0] want, paddr, base, size;
    logic [7:0]  mtype, typ;
    int          n_fail, comparisons;
    logic [112:0] vars [6] = '{{52'h2000000, 52'h2000000, 8'h05, 1'b1}, {52'h2000000, 52'h1000, 8'h00, 1'b1},
        {52'h8000000, 52'h1000000, 8'h04, 1'b1}, {52'h8000000, 52'h2000000, 8'h06, 1'b1},
        {52'h10000000, 52'h1000000, 8'h00, 1'b0}, {52'h0, 52'h100000, 8'h00, 1'b1}};
    logic [63:0] fx [4] = '{64'h0105040601050406, 64'h0606060606060606, 64'h0404040404040404,
        64'h0504010605040106};
    // address beside the type it should resolve to
    logic [59:0] rows [13] = '{{52'he0000, 8'h06}, {52'he7000, 8'h01}, {52'he9000, 8'h06}, {52'hf3000, 8'h04},
        {52'hff000, 8'h05}, {52'hd0000, 8'h00}, {52'h2000000, 8'h00}, {52'h2001000, 8'h05},
        {52'h3ffffff, 8'h05}, {52'h4000000, 8'h01}, {52'h8000000, 8'h04}, {52'h9000000, 8'h06},
        {52'h10000000, 8'h01}};

    mtl_type_lookup u_dut (
        .CLK_I       (clk),
        .RSTN_I      (rstn),
        .MSR_WR_I    (wr),
        .MSR_RD_I    (rd),
        .MSR_IDX_I   (idx),
        .MSR_WDATA_I (wdata),
        .MSR_RDATA_O (rdata),
        .MSR_ACK_O   (ack),
        .MSR_ERR_O   (err),
        .PADDR_I     (paddr),
        .MEM_TYPE_O  (mtype)
    );

    mtl_core_model u_core (
        .want_i     (want),
        .base_i     (base),
        .size_i     (size),
        .type_i     (typ),
        .vld_i      (vld),
        .paddr_o    (paddr),
        .base_reg_o (base_reg),
        .mask_reg_o (mask_reg)
    );

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one register access; a read also compares the data returned
    task automatic acc(input logic r, input logic [4:0] i, input logic [63:0] d, input logic e);
        @(posedge clk);
        #1;
        rd = r;
        wr = ~r;
        idx = i;
        wdata = d;
        @(posedge clk);
        #1;
        rd = 1'b0;
        wr = 1'b0;
        chk("ack", {63'h0, ack}, 64'h1);
        chk("err", {63'h0, err}, {63'h0, e});
        if (r) chk("rdata", rdata, d);
    endtask

    task automatic look(input logic [51:0] a, input logic [7:0] t);
        @(posedge clk);
        #1;
        want = a;
        #1;
        chk("type", {56'h0, mtype}, {56'h0, t});
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end

    initial begin
        {rstn, wr, rd, vld, idx, wdata, want, base, size, typ} = '0;
        repeat (5) @(posedge clk);
        #1;
        rstn = 1'b1;
        look(52'he0000, 8'h00);
        acc(1'b1, 5'h04, 64'h0, 1'b0);
        acc(1'b1, 5'h10, 64'h0, 1'b0);
        acc(1'b1, 5'h1f, 64'h0, 1'b0);
        for (int k = 0; k < 4; k++) acc(1'b0, 5'(k), fx[k], 1'b0);
        acc(1'b0, 5'h00, 64'h0000_0000_0000_0300, 1'b1);
        acc(1'b1, 5'h00, fx[0], 1'b0);
        for (int k = 0; k < 6; k++) begin
            {base, size, typ, vld} = vars[k];
            #1;
            acc(1'b0, 5'h10 + 5'(2 * k), base_reg, 1'b0);
            acc(1'b0, 5'h11 + 5'(2 * k), mask_reg, 1'b0);
        end
        acc(1'b0, 5'h04, 64'hc01, 1'b0);
        for (int k = 0; k < 13; k++) look(rows[k][59:8], rows[k][7:0]);
        acc(1'b1, 5'h10, 64'h0000_0000_0200_0005, 1'b0);
        acc(1'b1, 5'h11, 64'h000f_ffff_fe00_0800, 1'b0);
        acc(1'b1, 5'h05, 64'h0, 1'b1);
        acc(1'b0, 5'h04, 64'hec01, 1'b1);
        acc(1'b0, 5'h04, 64'hc07, 1'b1);
        acc(1'b0, 5'h14, 64'h0000_0000_0800_0002, 1'b1);
        acc(1'b1, 5'h14, 64'h0000_0000_0800_0004, 1'b0);
        acc(1'b1, 5'h04, 64'hc01, 1'b0);
        acc(1'b0, 5'h04, 64'h801, 1'b0);
        look(52'he0000, 8'h00);
        look(52'h9000000, 8'h06);
        look(52'h4000000, 8'h01);
        acc(1'b0, 5'h04, 64'h401, 1'b0);
        look(52'he0000, 8'h00);
        look(52'h4000000, 8'h00);
        acc(1'b0, 5'h04, 64'hc06, 1'b0);
        look(52'h4000000, 8'h06);
        @(posedge clk);
        #1;
        rstn = 1'b0;
        #1;
        chk("rst_type", {56'h0, mtype}, 64'h0);
        chk("rst_ack", {63'h0, ack}, 64'h0);
        @(posedge clk);
        #1;
        rstn = 1'b1;
        acc(1'b1, 5'h04, 64'h0, 1'b0);
        tally_and_finish();
    end
endmodule
